// file: inc/spbm_cfg.svh
`ifndef SPBM_CFG_SVH
`define SPBM_CFG_SVH
// Summary of operation
// - Manage 32 kB shared memory as 128-byte blocks, handed out per packet
// - At most 16 blocks per packet, chained as reception proceeds
// - Filtered, dropped or errored packets return all their blocks
// - Per-ingress block counts drive pause requests and a hard drop limit
// - Limits switch between fixed and programmed levels by active receivers
// - Multi-port block count at or above broadcast level drops multi-port packets
// - Drop-on-red set discards every Red packet
// - Drop-on-yellow set discards Yellow packets randomly by average usage
// - Discard table holds sixteen 10-bit probability entries
// - Table entry chosen by average usage in bands of sixteen blocks
// - Entry value N discards N-1 of every 1023 eligible packets
// - Packet is queued only after it is fully received
// - Four virtual unbounded priority queues per transmit port
// - Blocks of a sent packet are released for reuse
// - Fixed-priority bit set serves queue 3, then 2, 1, 0
// - Fixed-priority bit clear gives 9:4:2:1 weighted round-robin
// - Round-robin interleaves selections instead of bursts
// - Leaky-bucket limiter per queue per port, enabled individually
// - Limited queues are skipped so lower queues get served
// - After selection, wait per-byte time times length before reuse
// - Rate setting steps about 20 ns per byte, 0 to 3 give 80 ns
`define SPBM_NBLK      256
`define SPBM_MAXBLK    5'd16
`define SPBM_A_CFG     8'h00
`define SPBM_A_DROP    8'h04
`define SPBM_A_PAUSE   8'h08
`define SPBM_A_RESUME  8'h0c
`define SPBM_A_BCST    8'h10
`define SPBM_A_TCMD    8'h14
`define SPBM_A_TWR     8'h18
`define SPBM_A_TRD     8'h1c
`define SPBM_A_USE     8'h20
`define SPBM_A_STAT    8'h24
`define SPBM_RATE_PAGE 2'h1
`define SPBM_NQ        4'hc
`define SPBM_CFG_RED   0
`define SPBM_CFG_YEL   1
`define SPBM_CFG_FIX   2
`define SPBM_TCMD_WR   8
`define SPBM_TCMD_RD   9
`define SPBM_RATE_EN   16
`define SPBM_CFG_RST   3'h0
`define SPBM_DROP_RST  9'h050
`define SPBM_PAUSE_RST 9'h030
`define SPBM_RES_RST   9'h020
`define SPBM_BCST_RST  9'h040
`define SPBM_DROP_FIX  9'h0a0
`define SPBM_PAUSE_FIX 9'h080
`define SPBM_RES_FIX   9'h060
`define SPBM_WRR_SEQ   32'hfb7b_3b7b
`define SPBM_LFSR_SEED 10'h001
`define SPBM_STEP_NS   20
`define SPBM_CLK_NS    25
`define SPBM_RATE_MIN  13'h0004
`endif

// file: inc/spbm_pkg.sv
package spbm_pkg;
    typedef enum logic [1:0] {
        SPBM_IDLE = 2'b01,
        SPBM_FREE = 2'b10
    } spbm_state_t;
    typedef enum logic [1:0] {
        SPBM_GREEN  = 2'h0,
        SPBM_YELLOW = 2'h1,
        SPBM_RED    = 2'h2
    } spbm_color_t;
endpackage

// file: hw/spbm_shaper.sv
`timescale 1ns/1ps
`include "spbm_cfg.svh"
module spbm_shaper
    import spbm_pkg::*;
#(
    parameter int RW = 13,
    parameter int LW = 11,
    parameter int TW = 30
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          en_i,
    input  wire logic [RW-1:0] rate_i,
    input  wire logic          start_i,
    input  wire logic [LW-1:0] len_i,
    output logic               ready_o
);
    logic [TW-1:0] wait_q;
    logic [RW-1:0] eff;
    logic [TW-1:0] load;

    // Settings below four clamp to the 80 ns floor
    assign eff  = (rate_i < `SPBM_RATE_MIN) ? `SPBM_RATE_MIN : rate_i;
    // Wait in ns: setting times 20 ns times byte count
    assign load = TW'(eff) * TW'(len_i) * TW'(`SPBM_STEP_NS);

    // Count down in clock periods of the core clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q <= '0;
        end else if (start_i && en_i) begin
            wait_q <= load;
        end else if (wait_q > TW'(`SPBM_CLK_NS)) begin
            wait_q <= wait_q - TW'(`SPBM_CLK_NS);
        end else begin
            wait_q <= '0;
        end
    end

    // Disabled limiter never holds the queue back
    assign ready_o = !en_i || (wait_q == '0);
endmodule

// file: hw/spbm_top.sv
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "spbm_cfg.svh"
module spbm_top
    import spbm_pkg::*;
#(
    parameter int AVG_DIV = 64,
    parameter int LW      = 11
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic          alloc_req_i,
    input  wire logic          alloc_first_i,
    input  wire logic [1:0]    alloc_port_i,
    output logic               alloc_ack_o,
    output logic               alloc_ok_o,
    output logic      [7:0]    alloc_blk_o,
    input  wire logic          rxe_req_i,
    input  wire logic [1:0]    rxe_port_i,
    input  wire logic          rxe_good_i,
    input  wire logic [2:0]    rxe_dest_i,
    input  wire logic [1:0]    rxe_prio_i,
    input  wire logic [1:0]    rxe_color_i,
    input  wire logic [LW-1:0] rxe_len_i,
    output logic               rxe_ack_o,
    output logic               rxe_drop_o,
    output logic      [2:0]    fc_o,
    input  wire logic [2:0]    tx_req_i,
    output logic      [2:0]    tx_start_o,
    output logic      [7:0]    tx_blk_o,
    output logic      [LW-1:0] tx_len_o,
    input  wire logic [2:0]    tx_done_i,
    input  wire logic [7:0]    lnk_addr_i,
    output logic      [7:0]    lnk_next_o
);
    localparam int NB = `SPBM_NBLK;
    localparam logic [31:0] WRR = `SPBM_WRR_SEQ;

    // Block chains, free stack and per-packet records
    logic [7:0]    nxt_q  [NB];
    logic [7:0]    qnx_q  [3][NB];
    logic [7:0]    stk_q  [NB];
    logic [LW-1:0] plen_q [NB];
    logic [1:0]    pref_q [NB];
    logic [4:0]    pnb_q  [NB];
    logic [1:0]    psrc_q [NB];
    logic          pmul_q [NB];
    logic [8:0]    sp_q, fresh_q, bc_q;
    logic [7:0]    rh_q [3];
    logic [7:0]    rt_q [3];
    logic [4:0]    rn_q [3];
    logic [8:0]    use_q [3];
    logic [11:0]   acc_q [3];
    logic [7:0]    qh_q [3][4];
    logic [7:0]    qt_q [3][4];
    logic [8:0]    qc_q [3][4];
    logic [3:0]    ptr_q [3];
    logic [7:0]    cur_q [3];
    logic [2:0]    busy_q, dn_q, fc_q;
    spbm_state_t   st_q;
    logic [7:0]    walk_q;
    logic [4:0]    wrem_q;
    logic [1:0]    wsrc_q;
    logic [9:0]    rnd_q;
    logic [15:0]   div_q;
    // Software visible settings
    logic [2:0]    cfg_q;
    logic [8:0]    drop_q, pause_q, resume_q, bcst_q;
    logic [3:0]    tidx_q;
    logic [9:0]    twr_q, trd_q;
    logic [9:0]    tbl_q [16];
    logic [12:0]   rate_q [12];
    logic [11:0]   ren_q;
    logic          ack_q;
    logic [31:0]   dat_q;

    // Active receivers pick fixed or programmed limits
    logic [1:0] act;
    logic       many;
    logic [8:0] drop_thr, pause_thr, res_thr;
    assign act = {1'b0, use_q[0] != 9'h0} + {1'b0, use_q[1] != 9'h0}
               + {1'b0, use_q[2] != 9'h0};
    assign many      = act > 2'h1;
    assign drop_thr  = many ? drop_q   : `SPBM_DROP_FIX;
    assign pause_thr = many ? pause_q  : `SPBM_PAUSE_FIX;
    assign res_thr   = many ? resume_q : `SPBM_RES_FIX;

    // Queue eligibility and per-port selection
    logic [11:0] shp_rdy, shp_go;
    logic [3:0]  elig [3];
    logic [1:0]  pick [3];
    logic [2:0]  pv;
    logic [3:0]  aidx [3];
    always_comb begin
        logic [1:0] hi;
        logic [1:0] s;
        logic [8:0] avg;
        hi  = 2'h0;
        s   = 2'h0;
        avg = 9'h0;
        for (int p = 0; p < 3; p++) begin
            for (int q = 0; q < 4; q++) begin
                elig[p][q] = (qc_q[p][q] != 9'h0) && shp_rdy[p*4+q];
            end
            hi = elig[p][3] ? 2'h3 : elig[p][2] ? 2'h2 :
                 elig[p][1] ? 2'h1 : 2'h0;
            s  = WRR[{ptr_q[p], 1'b0} +: 2];
            pick[p] = (!cfg_q[`SPBM_CFG_FIX] && elig[p][s]) ? s : hi;
            pv[p]   = |elig[p];
            avg     = acc_q[p][11:3];
            aidx[p] = avg[8] ? 4'hf : avg[7:4];
        end
    end

    // Engine arbitration: release, dequeue, end of packet, allocation
    logic [2:0] want;
    logic [1:0] deq_p, rel_p, rp, ap, nd, dq;
    logic       idle, rel_go, deq_go, rxe_go, alc_go, rxe_pend;
    logic       yel_hit, rx_drop, have, alc_ok, rel_last;
    logic [7:0] rel_h, pop_blk, deq_h;
    assign idle     = st_q == SPBM_IDLE;
    assign want     = tx_req_i & ~busy_q & pv;
    assign deq_p    = want[0] ? 2'h0 : want[1] ? 2'h1 : 2'h2;
    assign rel_p    = dn_q[0] ? 2'h0 : dn_q[1] ? 2'h1 : 2'h2;
    assign rxe_pend = rxe_req_i && !rxe_ack_o;
    assign rel_go   = idle && (dn_q != 3'h0);
    assign deq_go   = idle && !rel_go && (want != 3'h0);
    assign rxe_go   = idle && !rel_go && (want == 3'h0) && rxe_pend;
    assign alc_go   = idle && !rel_go && (want == 3'h0) && !rxe_pend
                   && alloc_req_i && !alloc_ack_o;
    assign rel_h    = cur_q[rel_p];
    assign rel_last = pref_q[rel_h] == 2'h1;
    assign dq       = pick[deq_p];
    assign deq_h    = qh_q[deq_p][dq];

    // Discard decision at end of reception
    assign rp = rxe_port_i;
    assign nd = {1'b0, rxe_dest_i[0]} + {1'b0, rxe_dest_i[1]}
              + {1'b0, rxe_dest_i[2]};
    assign yel_hit = cfg_q[`SPBM_CFG_YEL] && rxe_color_i == SPBM_YELLOW
                  && (rnd_q < tbl_q[aidx[rp]]);
    assign rx_drop = !rxe_good_i || nd == 2'h0 || rn_q[rp] == 5'h0
                  || (nd > 2'h1 && bc_q >= bcst_q)
                  || (cfg_q[`SPBM_CFG_RED] && rxe_color_i == SPBM_RED);

    // Allocation check: free block, port limit, packet length
    assign ap      = alloc_port_i;
    assign have    = (sp_q != 9'h0) || (fresh_q != 9'(NB));
    assign pop_blk = (sp_q != 9'h0) ? stk_q[8'(sp_q - 9'h1)] : fresh_q[7:0];
    assign alc_ok  = have && (use_q[ap] < drop_thr)
                  && (alloc_first_i || rn_q[ap] < `SPBM_MAXBLK);

    // Main engine: one action per cycle in idle, one block per cycle in free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= SPBM_IDLE;
            sp_q <= 9'h0;
            fresh_q <= 9'h0;
            bc_q <= 9'h0;
            busy_q <= 3'h0;
            walk_q <= 8'h0;
            wrem_q <= 5'h0;
            wsrc_q <= 2'h0;
            for (int p = 0; p < 3; p++) begin
                use_q[p] <= 9'h0;
                rn_q[p] <= 5'h0;
                ptr_q[p] <= 4'h0;
                for (int q = 0; q < 4; q++) begin
                    qc_q[p][q] <= 9'h0;
                end
            end
        end else if (st_q == SPBM_FREE) begin
            stk_q[sp_q[7:0]] <= walk_q;
            sp_q <= sp_q + 9'h1;
            use_q[wsrc_q] <= use_q[wsrc_q] - 9'h1;
            walk_q <= nxt_q[walk_q];
            wrem_q <= wrem_q - 5'h1;
            if (wrem_q == 5'h1) begin
                st_q <= SPBM_IDLE;
            end
        end else if (rel_go) begin
            busy_q[rel_p] <= 1'b0;
            pref_q[rel_h] <= pref_q[rel_h] - 2'h1;
            if (rel_last) begin
                st_q <= SPBM_FREE;
                walk_q <= rel_h;
                wrem_q <= pnb_q[rel_h];
                wsrc_q <= psrc_q[rel_h];
                if (pmul_q[rel_h]) begin
                    bc_q <= bc_q - 9'(pnb_q[rel_h]);
                end
            end
        end else if (deq_go) begin
            busy_q[deq_p] <= 1'b1;
            cur_q[deq_p] <= deq_h;
            qh_q[deq_p][dq] <= qnx_q[deq_p][deq_h];
            qc_q[deq_p][dq] <= qc_q[deq_p][dq] - 9'h1;
            ptr_q[deq_p] <= ptr_q[deq_p] + 4'h1;
        end else if (rxe_go) begin
            rn_q[rp] <= 5'h0;
            if (rx_drop || yel_hit) begin
                if (rn_q[rp] != 5'h0) begin
                    st_q <= SPBM_FREE;
                    walk_q <= rh_q[rp];
                    wrem_q <= rn_q[rp];
                    wsrc_q <= rp;
                end
            end else begin
                plen_q[rh_q[rp]] <= rxe_len_i;
                pref_q[rh_q[rp]] <= nd;
                pnb_q[rh_q[rp]] <= rn_q[rp];
                psrc_q[rh_q[rp]] <= rp;
                pmul_q[rh_q[rp]] <= nd > 2'h1;
                if (nd > 2'h1) begin
                    bc_q <= bc_q + 9'(rn_q[rp]);
                end
                for (int d = 0; d < 3; d++) begin
                    if (rxe_dest_i[d]) begin
                        if (qc_q[d][rxe_prio_i] == 9'h0) begin
                            qh_q[d][rxe_prio_i] <= rh_q[rp];
                        end else begin
                            qnx_q[d][qt_q[d][rxe_prio_i]] <= rh_q[rp];
                        end
                        qt_q[d][rxe_prio_i] <= rh_q[rp];
                        qc_q[d][rxe_prio_i] <= qc_q[d][rxe_prio_i] + 9'h1;
                    end
                end
            end
        end else if (alc_go && alc_ok) begin
            if (sp_q != 9'h0) begin
                sp_q <= sp_q - 9'h1;
            end else begin
                fresh_q <= fresh_q + 9'h1;
            end
            use_q[ap] <= use_q[ap] + 9'h1;
            rt_q[ap] <= pop_blk;
            if (alloc_first_i) begin
                rh_q[ap] <= pop_blk;
                rn_q[ap] <= 5'h1;
            end else begin
                nxt_q[rt_q[ap]] <= pop_blk;
                rn_q[ap] <= rn_q[ap] + 5'h1;
            end
        end
    end

    // Answers to the packet-side requesters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alloc_ack_o <= 1'b0;
            alloc_ok_o <= 1'b0;
            alloc_blk_o <= 8'h0;
            rxe_ack_o <= 1'b0;
            rxe_drop_o <= 1'b0;
            tx_start_o <= 3'h0;
            tx_blk_o <= 8'h0;
            tx_len_o <= '0;
            lnk_next_o <= 8'h0;
        end else begin
            alloc_ack_o <= alc_go;
            alloc_ok_o <= alc_go && alc_ok;
            alloc_blk_o <= pop_blk;
            rxe_ack_o <= rxe_go;
            rxe_drop_o <= rxe_go && (rx_drop || yel_hit);
            tx_start_o <= deq_go ? 3'(3'h1 << deq_p) : 3'h0;
            tx_blk_o <= deq_h;
            tx_len_o <= plen_q[deq_h];
            lnk_next_o <= nxt_q[lnk_addr_i];
        end
    end

    // Done flags: a new done wins over the clear by release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dn_q <= 3'h0;
        end else begin
            dn_q <= (dn_q & ~(rel_go ? 3'(3'h1 << rel_p) : 3'h0))
                  | (tx_done_i & busy_q);
        end
    end

    // Pause request with hysteresis between pause and resume levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fc_q <= 3'h0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (use_q[p] >= pause_thr) begin
                    fc_q[p] <= 1'b1;
                end else if (use_q[p] <= res_thr) begin
                    fc_q[p] <= 1'b0;
                end
            end
        end
    end
    assign fc_o = fc_q;

    // Moving average of usage and random source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 16'h0;
            rnd_q <= `SPBM_LFSR_SEED;
            for (int p = 0; p < 3; p++) begin
                acc_q[p] <= 12'h0;
            end
        end else begin
            rnd_q <= {rnd_q[8:0], rnd_q[9] ^ rnd_q[6]};
            div_q <= (div_q == 16'(AVG_DIV - 1)) ? 16'h0 : div_q + 16'h1;
            if (div_q == 16'h0) begin
                for (int p = 0; p < 3; p++) begin
                    acc_q[p] <= acc_q[p] - {3'h0, acc_q[p][11:3]}
                              + {3'h0, use_q[p]};
                end
            end
        end
    end

    // Per-queue limiters
    assign shp_go = deq_go ? 12'(12'h1 << {deq_p, dq}) : 12'h0;
    for (genvar g = 0; g < 12; g++) begin : g_shp
        spbm_shaper #(.LW(LW)) u_shp (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .en_i    (ren_q[g]),
            .rate_i  (rate_q[g]),
            .start_i (shp_go[g]),
            .len_i   (plen_q[deq_h]),
            .ready_o (shp_rdy[g])
        );
    end

    // Wishbone decode, byte-lane merge and read mux
    logic        take, wr, rhit;
    logic [3:0]  ri;
    logic [31:0] rdat, bm, wd;
    assign take = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr   = take && wb_we_i;
    assign ri   = wb_adr_i[5:2];
    assign rhit = wb_adr_i[7:6] == `SPBM_RATE_PAGE && ri < `SPBM_NQ;
    assign bm   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wd   = (wb_dat_i & bm) | (rdat & ~bm);
    assign rdat =
        (wb_adr_i == `SPBM_A_CFG)    ? {29'h0, cfg_q} :
        (wb_adr_i == `SPBM_A_DROP)   ? {23'h0, drop_q} :
        (wb_adr_i == `SPBM_A_PAUSE)  ? {23'h0, pause_q} :
        (wb_adr_i == `SPBM_A_RESUME) ? {23'h0, resume_q} :
        (wb_adr_i == `SPBM_A_BCST)   ? {23'h0, bcst_q} :
        (wb_adr_i == `SPBM_A_TCMD)   ? {28'h0, tidx_q} :
        (wb_adr_i == `SPBM_A_TWR)    ? {22'h0, twr_q} :
        (wb_adr_i == `SPBM_A_TRD)    ? {22'h0, trd_q} :
        (wb_adr_i == `SPBM_A_USE)    ? {5'h0, use_q[2], use_q[1], use_q[0]} :
        (wb_adr_i == `SPBM_A_STAT)   ? {20'h0, fc_q, bc_q} :
        rhit ? {15'h0, ren_q[ri], 3'h0, rate_q[ri]} : 32'h0;

    // Bus answer one cycle after the request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= take;
            dat_q <= take ? rdat : 32'h0;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Register writes and indirect table access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= `SPBM_CFG_RST;
            drop_q <= `SPBM_DROP_RST;
            pause_q <= `SPBM_PAUSE_RST;
            resume_q <= `SPBM_RES_RST;
            bcst_q <= `SPBM_BCST_RST;
            tidx_q <= 4'h0;
            twr_q <= 10'h0;
            trd_q <= 10'h0;
            ren_q <= 12'h0;
            for (int i = 0; i < 16; i++) tbl_q[i] <= 10'h0;
            for (int i = 0; i < 12; i++) rate_q[i] <= 13'h0;
        end else if (wr) begin
            if (wb_adr_i == `SPBM_A_CFG) begin
                cfg_q <= wd[2:0];
            end else if (wb_adr_i == `SPBM_A_DROP) begin
                drop_q <= wd[8:0];
            end else if (wb_adr_i == `SPBM_A_PAUSE) begin
                pause_q <= wd[8:0];
            end else if (wb_adr_i == `SPBM_A_RESUME) begin
                resume_q <= wd[8:0];
            end else if (wb_adr_i == `SPBM_A_BCST) begin
                bcst_q <= wd[8:0];
            end else if (wb_adr_i == `SPBM_A_TCMD) begin
                tidx_q <= wd[3:0];
                if (wd[`SPBM_TCMD_WR]) tbl_q[wd[3:0]] <= twr_q;
                if (wd[`SPBM_TCMD_RD]) trd_q <= tbl_q[wd[3:0]];
            end else if (wb_adr_i == `SPBM_A_TWR) begin
                twr_q <= wd[9:0];
            end else if (rhit) begin
                rate_q[ri] <= wd[12:0];
                ren_q[ri] <= wd[`SPBM_RATE_EN];
            end
        end
    end
endmodule

// file: dv/spbm_sva.sv
`timescale 1ns/1ps
module spbm_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        alloc_req_i,
    input wire logic        alloc_ack_o,
    input wire logic        rxe_req_i,
    input wire logic        rxe_ack_o,
    input wire logic [2:0]  tx_req_i,
    input wire logic [2:0]  tx_start_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Register bus answers
    wb_ack_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    // Packet engine handshakes
    alloc_resp_a: assert property (
        alloc_req_i && !alloc_ack_o |-> ##[1:100] alloc_ack_o)
        else $error("block request unanswered");
    alloc_pulse_a: assert property (alloc_ack_o |=> !alloc_ack_o)
        else $error("block ack too long");
    rxe_resp_a: assert property (
        rxe_req_i && !rxe_ack_o |-> ##[1:100] rxe_ack_o)
        else $error("packet end unanswered");
    rxe_pulse_a: assert property (rxe_ack_o |=> !rxe_ack_o)
        else $error("packet end ack too long");
    // Transmit starts
    tx_onehot_a: assert property ($onehot0(tx_start_o))
        else $error("two ports started");
    tx_ready_a: assert property (
        |tx_start_o |-> (tx_start_o & ~$past(tx_req_i)) == 3'h0)
        else $error("start to port not ready");
endmodule

// file: dv/spbm_mac.sv
`timescale 1ns/1ps
module spbm_mac (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       hold_i,
    input  wire logic [3:0] dly_i,
    input  wire logic       start_i,
    output logic            req_o,
    output logic            done_o
);
    logic       busy_q;
    logic [4:0] cnt_q;
    // Ready only while idle and not stalled
    assign req_o = !busy_q && !hold_i && !rst_i;
    // Send takes dly_i+1 cycles, then one done pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            cnt_q  <= 5'h0;
            done_o <= 1'b0;
        end else if (start_i) begin
            busy_q <= 1'b1;
            cnt_q  <= {1'b0, dly_i} + 5'h1;
            done_o <= 1'b0;
        end else begin
            done_o <= busy_q && cnt_q == 5'h1;
            busy_q <= busy_q && cnt_q != 5'h1;
            cnt_q  <= cnt_q - 5'h1;
        end
    end
endmodule

// file: dv/spbm_top_tb.sv
`timescale 1ns/1ps
`include "spbm_cfg.svh"
module spbm_top_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]  wb_adr_i = 8'h00, lnk_addr_i = 8'h00, lnk_next_o;
    logic [3:0]  wb_sel_i = 4'hf, dly = 4'h2;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        alloc_req_i = 1'b0, alloc_first_i = 1'b0, alloc_ack_o;
    logic        alloc_ok_o, rxe_req_i = 1'b0, rxe_good_i = 1'b0;
    logic [1:0]  alloc_port_i = 2'h0, rxe_port_i = 2'h0;
    logic [1:0]  rxe_prio_i = 2'h0, rxe_color_i = 2'h0;
    logic        rxe_ack_o, rxe_drop_o;
    logic [2:0]  rxe_dest_i = 3'h0, fc_o, tx_req_i, tx_start_o;
    logic [2:0]  tx_done_i, hold = 3'h0;
    logic [10:0] rxe_len_i = 11'h0, tx_len_o, len;
    logic [7:0]  alloc_blk_o, tx_blk_o, blk;
    logic [9:0]  v;
    int          err_total = 0, tests_run = 0, cyc_n = 0;
    // Clock and the block under test with three egress MACs
    always #12.5 clk_i = ~clk_i;
    spbm_top #(.AVG_DIV(4), .LW(11)) i_dut (.*);
    for (genvar g = 0; g < 3; g++) begin : g_mac
        spbm_mac i_mac (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold[g]),
            .dly_i(dly), .start_i(tx_start_o[g]), .req_o(tx_req_i[g]),
            .done_o(tx_done_i[g]));
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // One-block packet: allocate, then end of packet; rd gets drop flag
    task automatic pkt(input logic [2:0] dst, input logic [1:0] pr,
                       input logic [1:0] col, input logic good);
        @(posedge clk_i);
        alloc_req_i   <= 1'b1;
        alloc_first_i <= 1'b1;
        do @(posedge clk_i); while (alloc_ack_o !== 1'b1);
        chk({31'h0, alloc_ok_o}, 32'h1);
        blk = alloc_blk_o;
        alloc_req_i <= 1'b0;
        rxe_req_i   <= 1'b1;
        rxe_good_i  <= good;
        rxe_dest_i  <= dst;
        rxe_prio_i  <= pr;
        rxe_color_i <= col;
        rxe_len_i   <= len;
        do @(posedge clk_i); while (rxe_ack_o !== 1'b1);
        rd = {31'h0, rxe_drop_o};
        rxe_req_i <= 1'b0;
    endtask
    task automatic txchk(input int g, input logic [10:0] l);
        int n;
        n = 0;
        do begin @(posedge clk_i); n++; end
        while (tx_start_o[g] !== 1'b1 && n < 300);
        chk({21'h0, tx_len_o}, {21'h0, l});
    endtask
    task automatic drain();
        rd = 32'h1;
        for (int k = 0; k < 30 && rd !== 32'h0; k++)
            wb(1'b0, `SPBM_A_USE, 32'h0);
        chk(rd, 32'h0);
    endtask
    // Red always dropped, yellow never with entry 0, errors dropped
    function automatic logic exp_drop(input int c, input logic good);
        return !good || c == 2;
    endfunction
    // Main sequence
    initial begin
        void'($urandom(32'h3cab));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(`SPBM_A_CFG, 32'h0);
        rdchk(`SPBM_A_DROP, 32'h50);
        rdchk(`SPBM_A_PAUSE, 32'h30);
        rdchk(`SPBM_A_RESUME, 32'h20);
        rdchk(`SPBM_A_BCST, 32'h40);
        rdchk(8'h30, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 16; i++) begin
            v = (i == 0) ? 10'h0 : 10'($urandom);
            wb(1'b1, `SPBM_A_TWR, {22'h0, v});
            wb(1'b1, `SPBM_A_TCMD, 32'h100 | 32'(i));
            wb(1'b1, `SPBM_A_TCMD, 32'h200 | 32'(i));
            rdchk(`SPBM_A_TRD, {22'h0, v});
        end
        wb(1'b1, `SPBM_A_TRD, 32'h3ff);
        rdchk(`SPBM_A_TRD, {22'h0, v});
        $display("test discard table done");
        wb(1'b1, `SPBM_A_CFG, 32'h3);
        for (int c = 0; c < 3; c++) for (int g = 0; g < 2; g++) begin
            len = 11'(1 + $urandom % 128);
            dly <= 4'($urandom);
            pkt(3'h4, 2'h1, 2'(c), g[0]);
            chk(rd, {31'h0, exp_drop(c, g[0])});
            if (!exp_drop(c, g[0])) begin
                txchk(2, len);
                chk({24'h0, tx_blk_o}, {24'h0, blk});
            end
        end
        drain();
        $display("test colour drop done");
        hold <= 3'h2;
        wb(1'b1, `SPBM_A_CFG, 32'h4);
        for (int q = 0; q < 4; q++) begin
            len = 11'(64 + q);
            pkt(3'h2, 2'(q), 2'h0, 1'b1);
        end
        rdchk(`SPBM_A_USE, 32'h4);
        hold <= 3'h0;
        for (int q = 3; q >= 0; q--) txchk(1, 11'(64 + q));
        drain();
        $display("test strict priority done");
        // Round-robin, then strict with queue 3 held back by its limiter
        for (int m = 0; m < 2; m++) begin
            hold <= 3'h2;
            wb(1'b1, `SPBM_A_CFG, (m == 1) ? 32'h4 : 32'h0);
            wb(1'b1, 8'h5c, (m == 1) ? 32'h0001_0000 : 32'h0);
            for (int k = 0; k < 3; k++) begin
                len = 11'(70 + k);
                pkt(3'h2, (k == 2) ? 2'h2 : 2'h3, 2'h0, 1'b1);
            end
            hold <= 3'h0;
            txchk(1, 11'h046);
            txchk(1, 11'h048);
            txchk(1, 11'h047);
            drain();
        end
        $display("test round robin and limiter done");
        // Packet for two ports counts in the broadcast total
        hold <= 3'h6;
        pkt(3'h6, 2'h0, 2'h0, 1'b1);
        rdchk(`SPBM_A_STAT, 32'h1);
        hold <= 3'h0;
        drain();
        rdchk(`SPBM_A_STAT, 32'h0);
        $display("test broadcast count done");
        finish_test();
    end
endmodule
bind spbm_top spbm_sva i_sva (.*);
